// ### hw/cbt_bit_timing.sv
// CAN bit-timing configuration register and nominal bit timing engine
// Notes on behaviour
// - quantum is DIV system clocks times prescale+1
// - effective prescale is stored value plus one
// - reserved bits read zero, writes ignored
// - effective jump width is field plus one
// - resync adjusts bit by at most jump width
// - triple sampling takes majority of three quanta
// - segment one length is field plus one
// - segment two length is field plus one
// - fields always readable, writes need protected init
`timescale 1ns/1ps
`default_nettype none
`include "cbt_defs.svh"

module cbt_bit_timing #(
    parameter int ADDR_W = 8,
    parameter int DIV = `CBT_MODULE_CLK_DIV
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // classic wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // bus side, level synchronous to clock
    input wire logic canRx,
    input wire logic busIdle,
    // timing engine results
    output logic sampledBit,
    output logic samplePulse,
    output logic bitStart,
    output var cbt_pkg::cbt_timing_t timing
);

    // elaboration check: decode uses address bits 7:2
    if (ADDR_W < 8 || ADDR_W > 32) begin : gAddrCheck
        $error("cbt_bit_timing: ADDR_W out of range");
    end

    // register state
    cbt_pkg::cbt_cfg_t cfg_reg;
    cbt_pkg::cbt_cfg_t cfg_next;
    logic initMode_reg;
    logic initMode_next;
    logic protWrite_reg;
    logic protWrite_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    cbt_pkg::cbt_timing_t timing_reg;
    cbt_pkg::cbt_timing_t timing_next;

    // engine state
    cbt_pkg::cbt_state_t state_reg;
    cbt_pkg::cbt_state_t state_next;
    logic [4:0] count_reg;
    logic [4:0] count_next;
    logic [2:0] extend_reg;
    logic [2:0] extend_next;
    logic [2:0] shorten_reg;
    logic [2:0] shorten_next;
    logic resyncDone_reg;
    logic resyncDone_next;
    logic prevRx_reg;
    logic prevRx_next;
    logic [1:0] rxHist_reg;
    logic [1:0] rxHist_next;
    logic sampled_reg;
    logic sampled_next;
    logic samplePulse_reg;
    logic samplePulse_next;
    logic bitStart_reg;
    logic bitStart_next;

    // helpers
    logic tqTick;
    logic hardSync;
    logic busEdge;
    logic access;
    logic [7:0] byteAdr;
    logic [31:0] cfgWord;
    logic [5:0] segOneEnd;
    logic [2:0] extendNew;
    logic [4:0] segTwoLeft;

    assign access = wb_cyc_i & wb_stb_i;
    assign byteAdr = {wb_adr_i[7:2], 2'b00};
    // reserved bits 31:24 and 15:10 read zero
    assign cfgWord = {8'h00, cfg_reg.prescaleValue, 6'h00, cfg_reg.resyncJumpWidth,
                      cfg_reg.tripleSampleSelect, cfg_reg.timeSegmentOne,
                      cfg_reg.timeSegmentTwo};

    // bus slave: ack one cycle after request, write lands on the ack edge
    always_comb begin
        cfg_next = cfg_reg;
        initMode_next = initMode_reg;
        protWrite_next = protWrite_reg;
        ack_next = access & ~ack_reg;
        rdata_next = rdata_reg;
        if (access & ~ack_reg) begin
            // reads allowed in every mode
            case (byteAdr)
                `CBT_BTC_OFFSET: begin
                    rdata_next = cfgWord;
                end
                `CBT_CTRL_OFFSET: begin
                    rdata_next = {30'h00000000, protWrite_reg, initMode_reg};
                end
                `CBT_STAT_OFFSET: begin
                    rdata_next = {24'h000000, resyncDone_reg, sampled_reg,
                                  count_reg, state_reg == cbt_pkg::CBT_SEG2};
                end
                default: begin
                    rdata_next = 32'h00000000;
                end
            endcase
        end
        if (access & ack_reg & wb_we_i) begin
            case (byteAdr)
                `CBT_BTC_OFFSET: begin
                    // config only changes under protected write in init mode
                    if (initMode_reg & protWrite_reg) begin
                        if (wb_sel_i[2]) begin
                            cfg_next.prescaleValue =
                                wb_dat_i[`CBT_PRESCALE_MSB:`CBT_PRESCALE_LSB];
                        end
                        if (wb_sel_i[1]) begin
                            cfg_next.resyncJumpWidth = wb_dat_i[`CBT_SJW_MSB:`CBT_SJW_LSB];
                        end
                        if (wb_sel_i[0]) begin
                            cfg_next.tripleSampleSelect = wb_dat_i[`CBT_TRIPLE_BIT];
                            cfg_next.timeSegmentOne = wb_dat_i[`CBT_SEG1_MSB:`CBT_SEG1_LSB];
                            cfg_next.timeSegmentTwo = wb_dat_i[`CBT_SEG2_MSB:`CBT_SEG2_LSB];
                        end
                    end
                end
                `CBT_CTRL_OFFSET: begin
                    if (wb_sel_i[0]) begin
                        initMode_next = wb_dat_i[`CBT_CTRL_INIT_BIT];
                        protWrite_next = wb_dat_i[`CBT_CTRL_PROT_BIT];
                    end
                end
                default: begin
                    initMode_next = initMode_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_reg <= cbt_pkg::cbt_cfg_t'(18'(`CBT_BTC_RESET));
            initMode_reg <= `CBT_CTRL_INIT_RESET;
            protWrite_reg <= `CBT_CTRL_PROT_RESET;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            cfg_reg <= cfg_next;
            initMode_reg <= initMode_next;
            protWrite_reg <= protWrite_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // effective values, each count field plus one, triple select copied as is
    always_comb begin
        timing_next.prescale = {1'b0, cfg_reg.prescaleValue} + 9'h001;
        timing_next.jumpWidth = {1'b0, cfg_reg.resyncJumpWidth} + 3'h1;
        timing_next.tripleSample = cfg_reg.tripleSampleSelect;
        timing_next.segOne = {1'b0, cfg_reg.timeSegmentOne} + 5'h01;
        timing_next.segTwo = {1'b0, cfg_reg.timeSegmentTwo} + 4'h1;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            timing_reg <= '0;
        end else begin
            timing_reg <= timing_next;
        end
    end

    // quantum grid, realigned on hard sync
    cbt_tq_gen #(
        .DIV(DIV)
    ) uTqGen (
        .clock(clock),
        .rst(rst),
        .restart(hardSync),
        .prescaleValue(cfg_reg.prescaleValue),
        .tqTick(tqTick)
    );

    // recessive to dominant edge seen on the quantum grid
    assign busEdge = tqTick & prevRx_reg & ~canRx;
    // hard sync on an idle bus edge, quantum grid is restarted with it
    assign hardSync = ~initMode_reg & busIdle & prevRx_reg & ~canRx;
    assign extendNew = ({2'b00, count_reg} + 5'h01 < {2'b00, timing_reg.jumpWidth})
                       ? 3'(count_reg + 5'h01) : timing_reg.jumpWidth;
    assign segTwoLeft = 5'(timing_reg.segTwo) - count_reg;

    // nominal bit engine, idle while in init mode
    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        extend_next = extend_reg;
        shorten_next = shorten_reg;
        resyncDone_next = resyncDone_reg;
        prevRx_next = prevRx_reg;
        rxHist_next = rxHist_reg;
        sampled_next = sampled_reg;
        samplePulse_next = 1'b0;
        bitStart_next = 1'b0;
        segOneEnd = 6'(timing_reg.segOne) + 6'(extend_reg) - 6'h01;
        if (initMode_reg) begin
            state_next = cbt_pkg::CBT_SYNC;
            count_next = 5'h00;
            extend_next = 3'h0;
            shorten_next = 3'h0;
            resyncDone_next = 1'b0;
            prevRx_next = 1'b1;
            rxHist_next = 2'b11;
        end else if (hardSync) begin
            // this quantum becomes the sync quantum of a new bit
            state_next = cbt_pkg::CBT_SYNC;
            count_next = 5'h00;
            extend_next = 3'h0;
            shorten_next = 3'h0;
            resyncDone_next = 1'b1;
            prevRx_next = canRx;
            rxHist_next = {rxHist_reg[0], canRx};
            bitStart_next = 1'b1;
        end else if (tqTick) begin
            prevRx_next = canRx;
            rxHist_next = {rxHist_reg[0], canRx};
            case (state_reg)
                cbt_pkg::CBT_SYNC: begin
                    // one sync quantum opens every bit
                    state_next = cbt_pkg::CBT_SEG1;
                    count_next = 5'h00;
                    extend_next = 3'h0;
                    shorten_next = 3'h0;
                    // resync budget reopens at segment two end, so a hard sync keeps it spent
                end
                cbt_pkg::CBT_SEG1: begin
                    if (busEdge & ~resyncDone_reg) begin
                        // late edge lengthens segment one, capped
                        extend_next = extendNew;
                        resyncDone_next = 1'b1;
                        segOneEnd = 6'(timing_reg.segOne) + 6'(extendNew) - 6'h01;
                    end
                    if ({1'b0, count_reg} >= segOneEnd) begin
                        // sample point sits between the two segments
                        state_next = cbt_pkg::CBT_SEG2;
                        count_next = 5'h00;
                        samplePulse_next = 1'b1;
                        if (timing_reg.tripleSample) begin
                            // majority of this and two earlier quanta
                            sampled_next = (rxHist_reg[0] & rxHist_reg[1]) |
                                           (rxHist_reg[0] & canRx) |
                                           (rxHist_reg[1] & canRx);
                        end else begin
                            sampled_next = canRx;
                        end
                    end else begin
                        count_next = count_reg + 5'h01;
                    end
                end
                cbt_pkg::CBT_SEG2: begin
                    if (busEdge & ~resyncDone_reg &
                        (segTwoLeft <= 5'(timing_reg.jumpWidth))) begin
                        // early edge ends the bit here, it acts as sync
                        state_next = cbt_pkg::CBT_SEG1;
                        count_next = 5'h00;
                        extend_next = 3'h0;
                        shorten_next = 3'h0;
                        resyncDone_next = 1'b1;
                        bitStart_next = 1'b1;
                    end else if (busEdge & ~resyncDone_reg) begin
                        // early edge shortens segment two by the jump width
                        shorten_next = timing_reg.jumpWidth;
                        resyncDone_next = 1'b1;
                        count_next = count_reg + 5'h01;
                    end else if (5'(count_reg) + 5'(shorten_reg) + 5'h01 >=
                                 5'(timing_reg.segTwo)) begin
                        // segment two over, next quantum syncs
                        state_next = cbt_pkg::CBT_SYNC;
                        count_next = 5'h00;
                        resyncDone_next = 1'b0;
                        bitStart_next = 1'b1;
                    end else begin
                        count_next = count_reg + 5'h01;
                    end
                end
                default: begin
                    state_next = cbt_pkg::CBT_SYNC;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= cbt_pkg::CBT_SYNC;
            count_reg <= 5'h00;
            extend_reg <= 3'h0;
            shorten_reg <= 3'h0;
            resyncDone_reg <= 1'b0;
            prevRx_reg <= 1'b1;
            rxHist_reg <= 2'b11;
            sampled_reg <= 1'b1;
            samplePulse_reg <= 1'b0;
            bitStart_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            extend_reg <= extend_next;
            shorten_reg <= shorten_next;
            resyncDone_reg <= resyncDone_next;
            prevRx_reg <= prevRx_next;
            rxHist_reg <= rxHist_next;
            sampled_reg <= sampled_next;
            samplePulse_reg <= samplePulse_next;
            bitStart_reg <= bitStart_next;
        end
    end

    // all outputs straight from flops
    assign wb_dat_o = rdata_reg;
    assign wb_ack_o = ack_reg;
    assign sampledBit = sampled_reg;
    assign samplePulse = samplePulse_reg;
    assign bitStart = bitStart_reg;
    assign timing = timing_reg;

endmodule

`default_nettype wire

// ### hw/cbt_defs.svh
// offsets, field positions, reset values and counts of the bit-timing block
`ifndef CBT_DEFS_SVH
`define CBT_DEFS_SVH

// register byte offsets
`define CBT_BTC_OFFSET 8'h00
`define CBT_CTRL_OFFSET 8'h04
`define CBT_STAT_OFFSET 8'h08

// bit_timing_config field positions
`define CBT_PRESCALE_MSB 23
`define CBT_PRESCALE_LSB 16
`define CBT_SJW_MSB 9
`define CBT_SJW_LSB 8
`define CBT_TRIPLE_BIT 7
`define CBT_SEG1_MSB 6
`define CBT_SEG1_LSB 3
`define CBT_SEG2_MSB 2
`define CBT_SEG2_LSB 0

// control register field positions
`define CBT_CTRL_INIT_BIT 0
`define CBT_CTRL_PROT_BIT 1

// reset values
`define CBT_BTC_RESET 24'h000000
`define CBT_CTRL_INIT_RESET 1'h1
`define CBT_CTRL_PROT_RESET 1'h0

// module clock is the system clock divided by this
`define CBT_MODULE_CLK_DIV 4

`endif

// ### hw/cbt_pkg.sv
// types shared by the bit-timing block
`default_nettype none
package cbt_pkg;

    // raw register fields as software stores them
    typedef struct packed {
        logic [7:0] prescaleValue;
        logic [1:0] resyncJumpWidth;
        logic tripleSampleSelect;
        logic [3:0] timeSegmentOne;
        logic [2:0] timeSegmentTwo;
    } cbt_cfg_t;

    // effective values as the engine uses them
    typedef struct packed {
        logic [8:0] prescale;
        logic [2:0] jumpWidth;
        logic tripleSample;
        logic [4:0] segOne;
        logic [3:0] segTwo;
    } cbt_timing_t;

    // position within one nominal bit
    typedef enum logic [1:0] {
        CBT_SYNC,
        CBT_SEG1,
        CBT_SEG2
    } cbt_state_t;

endpackage

`default_nettype wire

// ### hw/cbt_tq_gen.sv
// time quantum tick generator from the system clock
`timescale 1ns/1ps
`default_nettype none
`include "cbt_defs.svh"

module cbt_tq_gen #(
    parameter int DIV = `CBT_MODULE_CLK_DIV
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic restart,
    input wire logic [7:0] prescaleValue,
    // tick, one cycle per time quantum
    output logic tqTick
);

    // elaboration check: divider must fit the 16-bit counter
    if (DIV < 1 || DIV > 255) begin : gDivCheck
        $error("cbt_tq_gen: DIV out of range");
    end

    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic tick_reg;
    logic tick_next;
    logic [15:0] terminal;

    // one quantum is (prescale + 1) module clocks of DIV system clocks
    assign terminal = 16'(({8'h00, prescaleValue} + 16'h0001) * 16'(DIV)) - 16'h0001;

    // restart realigns the quantum grid, used by hard sync
    always_comb begin
        count_next = count_reg + 16'h0001;
        tick_next = 1'b0;
        if (restart) begin
            count_next = 16'h0000;
        end else if (count_reg >= terminal) begin
            count_next = 16'h0000;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            count_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg <= tick_next;
        end
    end

    assign tqTick = tick_reg;

endmodule

`default_nettype wire

// ### verification/cbt_bit_timing_assertions.sv
// port-level checks on the bit-timing block
`timescale 1ns/1ps
`default_nettype none
module cbt_bit_timing_checker #(
    parameter int ADDR_W = 8,
    parameter int DIV = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // bus side and engine
    input wire logic canRx,
    input wire logic busIdle,
    input wire logic sampledBit,
    input wire logic samplePulse,
    input wire logic bitStart,
    input wire cbt_pkg::cbt_timing_t timing
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ack answers every taken request, one cycle wide
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    // effective counts never show zero and stay in range once out of reset
    a_prescale_range: assert property (timing != '0 |-> timing.prescale != 9'h000)
        else $error("effective prescale zero");
    a_jump_range: assert property (timing != '0 |-> timing.jumpWidth inside {[3'h1:3'h4]})
        else $error("jump width out of range");
    a_seg_range: assert property (timing != '0 |-> timing.segOne != 5'h00 &&
        timing.segOne <= 5'h10 && timing.segTwo inside {[4'h1:4'h8]})
        else $error("segment length out of range");
    // timing only moves after a bus write
    a_timing_write: assert property ($changed(timing) && $past(timing) != '0
        |-> $past(wb_ack_o && wb_we_i, 2))
        else $error("timing changed without write");
    // sampled level changes only at a sample point
    a_sample_only: assert property ($changed(sampledBit) |-> samplePulse)
        else $error("sampled bit moved outside sample point");
    // sample pulses are at least one module clock apart
    a_tq_spacing: assert property (samplePulse |=> !samplePulse [*3])
        else $error("sample pulses too close");
    a_sample_apart: assert property (samplePulse |-> !bitStart)
        else $error("sample point at bit start");
    a_bit_pulse: assert property (bitStart |=> !bitStart)
        else $error("bit start longer than one cycle");
endmodule
bind cbt_bit_timing cbt_bit_timing_checker #(.ADDR_W(ADDR_W), .DIV(DIV)) u_cbt_bit_timing_checker (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .canRx(canRx), .busIdle(busIdle), .sampledBit(sampledBit),
    .samplePulse(samplePulse), .bitStart(bitStart), .timing(timing));
`default_nettype wire

// ### verification/cbt_can_bus_model.sv
// behavioural model of the bus and the other nodes
`timescale 1ns/1ps
`default_nettype none
module cbt_can_bus_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // commands from the bench
    input wire logic dominantReq,
    input wire logic idleReq,
    // bus levels
    output logic canRx,
    output logic busIdle
);
    // wired-and bus: recessive unless some node pulls it dominant
    always_ff @(posedge clock) begin
        if (rst) begin
            canRx <= 1'b1;
            busIdle <= 1'b0;
        end else begin
            canRx <= !dominantReq;
            busIdle <= idleReq;
        end
    end
endmodule
`default_nettype wire

// ### verification/tb_cbt_bit_timing.sv
// self-checking bench of the bit-timing block
`timescale 1ns/1ps
`default_nettype none
module tb_cbt_bit_timing;
    logic clock;
    logic rst;
    logic wbCyc;
    logic wbStb;
    logic wbWe;
    logic [7:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDat;
    logic [31:0] wbDatO;
    logic wbAck;
    logic canRx;
    logic busIdle;
    logic sampledBit;
    logic samplePulse;
    logic bitStart;
    logic dominantReq;
    logic idleReq;
    logic [31:0] rd;
    cbt_pkg::cbt_timing_t timing;
    int failures;
    int tests_run;

    cbt_bit_timing u_cbt_bit_timing (.clock(clock), .rst(rst), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
        .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .canRx(canRx),
        .busIdle(busIdle), .sampledBit(sampledBit), .samplePulse(samplePulse),
        .bitStart(bitStart), .timing(timing));
    cbt_can_bus_model u_cbt_can_bus_model (.clock(clock), .rst(rst),
        .dominantReq(dominantReq), .idleReq(idleReq), .canRx(canRx), .busIdle(busIdle));

    initial begin
        clock = 1'b0;
        forever #50 clock = !clock;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one classic cycle; the answer is waited for, never assumed
    task automatic wbAccess(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= 4'hf;
        wbDat <= dat;
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge clock);
        if (n >= 20) begin
            failures++;
            wrap_up();
        end
    endtask

    // bounded wait for a one-cycle engine pulse, counting clocks
    task automatic waitPulse(input bit sample, output int n);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while ((sample ? samplePulse : bitStart) !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            failures++;
            wrap_up();
        end
    endtask

    task automatic scenarioReset();
        wbAccess(1'b0, 8'h00, 32'h0);
        check32("config after reset", 32'h0, rd);
        wbAccess(1'b0, 8'h04, 32'h0);
        check32("ctrl after reset", 32'h1, rd);
        check32("timing after reset", {10'h0, 9'h001, 3'h1, 1'b0, 5'h01, 4'h1}, 32'(timing));
    endtask

    task automatic scenarioProtect();
        wbAccess(1'b1, 8'h00, 32'hffffffff);
        wbAccess(1'b0, 8'h00, 32'h0);
        check32("unprotected write", 32'h0, rd);
        wbAccess(1'b1, 8'h04, 32'h3);
        wbAccess(1'b1, 8'h00, 32'hffffffff);
        wbAccess(1'b0, 8'h00, 32'h0);
        check32("reserved bits", 32'h00ff03ff, rd);
        check32("timing maximum", {10'h0, 9'h100, 3'h4, 1'b1, 5'h10, 4'h8}, 32'(timing));
        wbAccess(1'b1, 8'h0c, 32'hffffffff);
        wbAccess(1'b0, 8'h0c, 32'h0);
        check32("unmapped read", 32'h0, rd);
        // protection dropped: config must keep its value
        wbAccess(1'b1, 8'h04, 32'h1);
        wbAccess(1'b1, 8'h00, 32'h0);
        wbAccess(1'b0, 8'h00, 32'h0);
        check32("write without protection", 32'h00ff03ff, rd);
    endtask

    // prescale 2, segment one 4, segment two 3: a bit of 8 quanta of 8 clocks
    task automatic scenarioBitLayout();
        int toSample;
        int toStart;
        wbAccess(1'b1, 8'h04, 32'h3);
        wbAccess(1'b1, 8'h00, 32'h0001001a);
        wbAccess(1'b1, 8'h04, 32'h0);
        waitPulse(1'b0, toStart);
        waitPulse(1'b1, toSample);
        waitPulse(1'b0, toStart);
        check32("sync and segment one clocks", 32'd40, 32'(toSample));
        check32("segment two clocks", 32'd24, 32'(toStart));
        check32("recessive sample", 32'h1, {31'h0, sampledBit});
    endtask

    // late edge two quanta into segment one: stretch capped at one jump width
    task automatic scenarioResync();
        int n;
        waitPulse(1'b0, n);
        repeat (16) @(posedge clock);
        dominantReq <= 1'b1;
        waitPulse(1'b1, n);
        // 40 clocks to the sample point plus one 8-clock quantum, not two
        check32("late edge stretch clocks", 32'd48, 32'(n + 16));
        dominantReq <= 1'b0;
    endtask

    // idle bus falling dominant restarts the grid, that quantum is the sync one
    task automatic scenarioHardSync();
        int n;
        waitPulse(1'b1, n);
        idleReq <= 1'b1;
        dominantReq <= 1'b1;
        waitPulse(1'b1, n);
        // sync plus segment one is 40 clocks, a few more for bus and detect latency
        check32("hard sync to sample", 32'h1, {31'h0, n >= 40 && n <= 44});
        check32("dominant sample", 32'h0, {31'h0, sampledBit});
        dominantReq <= 1'b0;
        idleReq <= 1'b0;
    endtask

    // prescale 5, triple on: two dominant quanta outvote a recessive sample point
    task automatic scenarioTriple();
        int n;
        wbAccess(1'b1, 8'h04, 32'h3);
        wbAccess(1'b1, 8'h00, 32'h0004009a);
        wbAccess(1'b1, 8'h04, 32'h0);
        waitPulse(1'b0, n);
        // dominant from the sync quantum, released before the sample quantum
        dominantReq <= 1'b1;
        repeat (85) @(posedge clock);
        dominantReq <= 1'b0;
        waitPulse(1'b1, n);
        check32("triple sample vote", 32'h0, {31'h0, sampledBit});
    endtask

    initial begin
        rst = 1'b1;
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 8'h00;
        wbSel = 4'h0;
        wbDat = 32'h0;
        dominantReq = 1'b0;
        idleReq = 1'b0;
        failures = 0;
        tests_run = 0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        scenarioReset();
        scenarioProtect();
        scenarioBitLayout();
        scenarioResync();
        scenarioHardSync();
        scenarioTriple();
        wrap_up();
    end
endmodule
`default_nettype wire
